//--- inc/lipm_defines.svh
// Offsets, field positions, reset values and counts for the LED intensity PWM.
// Assumes inclusion by its bare name from the package and the design files.
`ifndef LIPM_DEFINES_SVH
`define LIPM_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define LIPM_ADDR_MASTER 8'h0E
`define LIPM_RESET_VALUE 8'h00
`define LIPM_RDATA_NONE 8'h00
`define LIPM_MASTER_MSB 7
`define LIPM_MASTER_LSB 4
`define LIPM_NINTH_MSB 3
`define LIPM_NINTH_LSB 0

// ----------------------------------------------------------------------------
// Codes and counts
// ----------------------------------------------------------------------------
`define LIPM_CODE_STATIC 4'hF
`define LIPM_CODE_HALF 4'h7
`define LIPM_MASTER_OFF 4'h0
`define LIPM_LAST_STEP 4'hF
`define LIPM_LAST_SLOT 4'hE
`define LIPM_PORT_COUNT 8
`define LIPM_OUT_COUNT 9
`define LIPM_NINTH_INDEX 8

`endif

//--- inc/lipm_pkg.sv
// Types shared by the LED intensity PWM design files.
// Assumes the defines header is on the include path.
`include "lipm_defines.svh"

package lipm_pkg;

   // -------------------------------------------------------------------------
   // Register contents and register request
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [3:0] master_level;
      logic [3:0] ninth_out_level;
   } lipm_reg_s;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      lipm_reg_s wdata;
   } lipm_req_s;

   // -------------------------------------------------------------------------
   // Output cell modes
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      LIPM_OFF,
      LIPM_PWM,
      LIPM_STATIC
   } lipm_mode_e;

endpackage : lipm_pkg

//--- src/lipm_pwm_cell.sv
// One open-drain PWM output cell of the LED intensity block.
// Assumes a shared step counter and master slot gate from the parent.
`timescale 1ns/1ns
`include "lipm_defines.svh"

module lipm_pwm_cell (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] code,
   input wire logic phase_bit,
   input wire logic master_on,
   input wire logic [3:0] step,
   output logic oe_n_q
);
   import lipm_pkg::*;

   lipm_mode_e mode;
   logic [4:0] thr;
   logic low_d;

   // -------------------------------------------------------------------------
   // Duty decision
   // -------------------------------------------------------------------------
   always_comb begin
      thr = {1'b0, code} + 5'h01;
      if (code == `LIPM_CODE_STATIC) begin // see RULE6
         mode = LIPM_STATIC;
      end else if (master_on) begin // see RULE14
         mode = LIPM_PWM;
      end else begin
         mode = LIPM_OFF;
      end
      case (mode)
         LIPM_STATIC: begin
            low_d = ~phase_bit; // see RULE10 see RULE12
         end
         LIPM_PWM: begin
            if (phase_bit) begin
               low_d = ({1'b0, step} >= thr); // see RULE8 see RULE9
            end else begin
               low_d = ({1'b0, step} < thr); // see RULE5 see RULE7
            end
         end
         default: begin
            low_d = 1'b0; // see RULE3
         end
      endcase
   end

   // -------------------------------------------------------------------------
   // Output enable, low while the pin is pulled low
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         oe_n_q <= 1'b1;
      end else begin
         oe_n_q <= ~low_d;
      end
   end

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   static_low_a: assert property ( // see RULE10
      code == `LIPM_CODE_STATIC && !phase_bit |=> !oe_n_q)
      else $error("static code with phase bit 0 did not hold low");
   static_hiz_a: assert property ( // see RULE12
      code == `LIPM_CODE_STATIC && phase_bit |=> oe_n_q)
      else $error("static code with phase bit 1 did not release");
   half_duty_a: assert property ( // see RULE9
      code == `LIPM_CODE_HALF && master_on
      |=> oe_n_q == ($past(step[3]) ^ $past(phase_bit)))
      else $error("half code not low for half of the step frame");
   first_step_a: assert property ( // see RULE5
      code != `LIPM_CODE_STATIC && master_on && step == 4'h0
      |=> oe_n_q == $past(phase_bit))
      else $error("first step polarity wrong");
   last_step_a: assert property ( // see RULE8
      code != `LIPM_CODE_STATIC && master_on && step == `LIPM_LAST_STEP
      |=> oe_n_q == !$past(phase_bit))
      else $error("last step polarity wrong");
   gate_off_a: assert property ( // see RULE3
      code != `LIPM_CODE_STATIC && !master_on |=> oe_n_q)
      else $error("output pulled low outside master on-time");
   static_c: cover property (code == `LIPM_CODE_STATIC ##1 !oe_n_q);

endmodule : lipm_pwm_cell

//--- src/lipm_intensity.sv
// Master and ninth output intensity register with the PWM time base.
// Assumes a serial front end that turns bus transfers into register strobes,
// and external registers that supply per-port codes and blink phase bits.
//
// Functional notes
// RULE1: Register holds master and ninth-output codes.
// RULE2: Reads return stored fields in place.
// RULE3: Master zero stops oscillator, outputs static.
// RULE4: Master code n gives n fifteenths duty.
// RULE5: Ninth code n gives n+1 sixteenths.
// RULE6: Ninth code fifteen is static, no PWM.
// RULE7: Phase bit 0: low n+1 sixteenths.
// RULE8: Phase bit 1: low 15-n sixteenths.
// RULE9: Code seven is half in both phases.
// RULE10: Blinking, code fifteen static by phase bit.
// RULE11: Individual or global codes, same mapping.
// RULE12: Not blinking, code fifteen follows phase-0 bit.
// RULE13: Ninth output switched by its own register.
// RULE14: Individual steps subdivide master on-time.
`timescale 1ns/1ns
`include "lipm_defines.svh"

module lipm_intensity (
   input wire logic CLK,
   input wire logic RST,
   input wire lipm_pkg::lipm_req_s REG_REQ,
   output lipm_pkg::lipm_reg_s REG_RDATA,
   input wire logic [31:0] PORT_LEVELS,
   input wire logic GLOBAL_EN,
   input wire logic BLINK_EN,
   input wire logic BLINK_PHASE,
   input wire logic [8:0] PHASE0_BITS,
   input wire logic [8:0] PHASE1_BITS,
   output logic [7:0] LED_PORT_O,
   output logic [7:0] LED_PORT_OE_N,
   output logic NINTH_O,
   output logic NINTH_OE_N,
   output logic OSC_RUN
);
   import lipm_pkg::*;

   lipm_reg_s level_q;
   lipm_reg_s rdata_q;
   logic [3:0] step_q;
   logic [3:0] slot_q;
   logic osc_run;
   logic osc_run_q;
   logic master_on;
   logic [8:0] zero_q;
   logic [3:0] codes [0:8];
   logic [8:0] phase_sel;
   logic [8:0] oe_n;
   logic hit;

   assign hit = (REG_REQ.addr == `LIPM_ADDR_MASTER);

   // -------------------------------------------------------------------------
   // Intensity register
   // -------------------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         level_q <= `LIPM_RESET_VALUE;
      end else if (REG_REQ.wr && hit) begin
         level_q <= REG_REQ.wdata; // see RULE1
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         rdata_q <= `LIPM_RDATA_NONE;
      end else if (REG_REQ.rd) begin
         if (hit) begin
            rdata_q <= level_q; // see RULE2
         end else begin
            rdata_q <= `LIPM_RDATA_NONE;
         end
      end
   end

   assign REG_RDATA = rdata_q;

   // -------------------------------------------------------------------------
   // Time base: 15 master slots of 16 steps each
   // -------------------------------------------------------------------------
   assign osc_run = (level_q.master_level != `LIPM_MASTER_OFF); // see RULE3

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         step_q <= 4'h0;
      end else if (!osc_run) begin
         step_q <= 4'h0; // see RULE3
      end else begin
         step_q <= step_q + 4'h1; // see RULE14
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         slot_q <= 4'h0;
      end else if (!osc_run) begin
         slot_q <= 4'h0;
      end else if (step_q == `LIPM_LAST_STEP) begin
         if (slot_q == `LIPM_LAST_SLOT) begin
            slot_q <= 4'h0; // see RULE4
         end else begin
            slot_q <= slot_q + 4'h1;
         end
      end
   end

   // Master code n opens the first n of the 15 slots.
   assign master_on = osc_run && (slot_q < level_q.master_level); // see RULE4

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         osc_run_q <= 1'b0;
      end else begin
         osc_run_q <= osc_run;
      end
   end

   assign OSC_RUN = osc_run_q;

   // -------------------------------------------------------------------------
   // Output cells
   // -------------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `LIPM_OUT_COUNT; gi = gi + 1) begin : g_out
         if (gi == `LIPM_NINTH_INDEX) begin : g_ninth
            // The ninth output takes its code from its own register field.
            assign codes[gi] = level_q.ninth_out_level; // see RULE13
         end else begin : g_port
            assign codes[gi] = GLOBAL_EN ? level_q.ninth_out_level
                                         : PORT_LEVELS[4*gi +: 4]; // see RULE11
         end
         // Without blinking only the phase-0 bit applies.
         assign phase_sel[gi] = (BLINK_EN && BLINK_PHASE) ? PHASE1_BITS[gi]
                                                          : PHASE0_BITS[gi];
         lipm_pwm_cell u_cell (
            .clk(CLK),
            .rst(RST),
            .code(codes[gi]),
            .phase_bit(phase_sel[gi]),
            .master_on(master_on),
            .step(step_q),
            .oe_n_q(oe_n[gi])
         );
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Open-drain data: the pins only ever pull low
   // -------------------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         zero_q <= 9'h000;
      end else begin
         zero_q <= 9'h000;
      end
   end

   assign LED_PORT_O = zero_q[7:0];
   assign NINTH_O = zero_q[8];
   assign LED_PORT_OE_N = oe_n[7:0];
   assign NINTH_OE_N = oe_n[8];

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   reg_write_a: assert property ( // see RULE1
      REG_REQ.wr && hit |=> level_q == $past(REG_REQ.wdata))
      else $error("register write not stored");
   reg_read_a: assert property ( // see RULE2
      REG_REQ.rd && hit && !REG_REQ.wr |=> REG_RDATA == $past(level_q))
      else $error("register read did not return stored fields");
   unmapped_read_a: assert property (
      REG_REQ.rd && !hit |=> REG_RDATA == `LIPM_RDATA_NONE)
      else $error("unmapped read returned data");
   osc_stop_a: assert property ( // see RULE3
      !osc_run |=> step_q == 4'h0 && slot_q == 4'h0 && master_on == osc_run)
      else $error("time base ran with master code zero");
   slot_wrap_a: assert property ( // see RULE4
      osc_run && step_q == `LIPM_LAST_STEP && slot_q == `LIPM_LAST_SLOT
      && $stable(level_q) |=> slot_q == 4'h0 ##15 slot_q == 4'h0)
      else $error("master slot frame is not fifteen slots");
   full_master_a: assert property ( // see RULE4
      level_q.master_level == 4'hF |-> master_on)
      else $error("full master code left a slot closed");
   step_run_a: assert property ( // see RULE14
      osc_run |=> step_q == $past(step_q) + 4'h1)
      else $error("step counter did not advance while running");
   global_code_a: assert property ( // see RULE11
      GLOBAL_EN |-> codes[0] == level_q.ninth_out_level)
      else $error("global code not applied to ports");
   osc_flag_a: assert property (
      osc_run |=> OSC_RUN)
      else $error("oscillator status not shown");
   rdata_hold_a: assert property ( // see RULE2
      !REG_REQ.rd |=> $stable(REG_RDATA))
      else $error("read data changed without a read strobe");
   ninth_static_a: assert property ( // see RULE6
      level_q.ninth_out_level == `LIPM_CODE_STATIC && !phase_sel[8]
      |=> !NINTH_OE_N)
      else $error("ninth output not held low by its static code");
   master_off_a: assert property ( // see RULE3
      !osc_run && codes[0] != `LIPM_CODE_STATIC |=> LED_PORT_OE_N[0])
      else $error("port pulled low with master code zero");
   ninth_own_a: assert property ( // see RULE13
      level_q.ninth_out_level != `LIPM_CODE_STATIC && !master_on
      |=> NINTH_OE_N)
      else $error("ninth output pulled low outside its on-time");
   ninth_first_a: assert property ( // see RULE5
      level_q.ninth_out_level != `LIPM_CODE_STATIC && master_on
      && step_q == 4'h0 && !phase_sel[8] |=> !NINTH_OE_N)
      else $error("ninth output not low at the first step");

   master_off_c: cover property (osc_run ##1 !osc_run);
   slot_wrap_c: cover property (slot_q == `LIPM_LAST_SLOT ##16 slot_q == 4'h0);
   blink_c: cover property (BLINK_EN && BLINK_PHASE && master_on);
   global_c: cover property (GLOBAL_EN && master_on);

endmodule : lipm_intensity

//--- verification/lipm_host.sv
// Host model that issues register strobes to the intensity block.
// Assumes requests are taken at the rising CLK edge with no ready signal.
`timescale 1ns/1ns

module lipm_host (
   input wire logic CLK,
   input wire lipm_pkg::lipm_reg_s REG_RDATA,
   output lipm_pkg::lipm_req_s REG_REQ
);
   import lipm_pkg::*;

   // ------------------------------------------------------------------------
   // Request tasks
   // ------------------------------------------------------------------------
   initial begin
      REG_REQ = '0;
   end

   // Holds one write strobe over exactly one sampling edge.
   task automatic write_reg(input logic [7:0] addr, input lipm_reg_s data);
      @(posedge CLK);
      REG_REQ <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge CLK);
      REG_REQ <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
   endtask : write_reg

   // Read data is taken once the registered answer has landed.
   task automatic read_reg(input logic [7:0] addr, output lipm_reg_s data);
      @(posedge CLK);
      REG_REQ <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: REG_REQ.wdata};
      @(posedge CLK);
      REG_REQ <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: REG_REQ.wdata};
      #1;
      data = REG_RDATA;
   endtask : read_reg

endmodule : lipm_host

//--- verification/tb_led_intensity_pwm_master_ninth_output.sv
// Self-checking bench for the master and ninth output intensity block.
// Assumes the host model drives the register strobes.
`timescale 1ns/1ns

module tb_led_intensity_pwm_master_ninth_output;
   import lipm_pkg::*;

   logic CLK = 1'b0;
   logic RST = 1'b1;
   lipm_req_s REG_REQ;
   lipm_reg_s REG_RDATA;
   lipm_reg_s rd_q;
   logic [31:0] PORT_LEVELS = 32'h0;
   logic GLOBAL_EN = 1'b0, BLINK_EN = 1'b0, BLINK_PHASE = 1'b0;
   logic [8:0] PHASE0_BITS = 9'h0, PHASE1_BITS = 9'h0;
   logic [7:0] LED_PORT_O, LED_PORT_OE_N;
   logic NINTH_O, NINTH_OE_N, OSC_RUN;
   logic [8:0] oe_seen;
   logic [8:0] lows [9];
   integer err_count = 0, num_checks = 0, seed = 99;

   always #4 CLK = ~CLK;

   assign oe_seen = {NINTH_OE_N, LED_PORT_OE_N};

   lipm_host i_lipm_host (.CLK(CLK), .REG_RDATA(REG_RDATA), .REG_REQ(REG_REQ));

   lipm_intensity i_lipm_intensity (
      .CLK(CLK), .RST(RST), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
      .PORT_LEVELS(PORT_LEVELS), .GLOBAL_EN(GLOBAL_EN),
      .BLINK_EN(BLINK_EN), .BLINK_PHASE(BLINK_PHASE),
      .PHASE0_BITS(PHASE0_BITS), .PHASE1_BITS(PHASE1_BITS),
      .LED_PORT_O(LED_PORT_O), .LED_PORT_OE_N(LED_PORT_OE_N),
      .NINTH_O(NINTH_O), .NINTH_OE_N(NINTH_OE_N), .OSC_RUN(OSC_RUN)
   );

   // ------------------------------------------------------------------------
   // Checking and expectation helpers
   // ------------------------------------------------------------------------
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic results();
      $display("Checks %0d, mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results

   // Low cycles of one output over a full 240-cycle master frame.
   function automatic logic [8:0] exp_low(input logic [3:0] m,
                                          input logic [3:0] c, input logic pb);
      if (c == 4'hF) return pb ? 9'h000 : 9'h0F0;
      if (m == 4'h0) return 9'h000;
      return pb ? {5'h00, m} * (9'h00F - {5'h00, c})
                : {5'h00, m} * ({5'h00, c} + 9'h001);
   endfunction : exp_low

   task automatic drive(input logic [31:0] lv, input logic [2:0] fl,
                        input logic [8:0] p0, input logic [8:0] p1);
      @(posedge CLK);
      PORT_LEVELS <= lv;
      {GLOBAL_EN, BLINK_EN, BLINK_PHASE} <= fl;
      PHASE0_BITS <= p0;
      PHASE1_BITS <= p1;
   endtask : drive

   task automatic run_round(input logic [3:0] m, input logic [3:0] g);
      logic [3:0] c;
      logic pb;
      i_lipm_host.write_reg(8'h0E, {m, g});
      i_lipm_host.read_reg(8'h0E, rd_q);
      check({1'b0, rd_q}, {1'b0, m, g});
      repeat (3) @(posedge CLK);
      #1 check({8'h00, OSC_RUN}, {8'h00, m != 4'h0});
      check({NINTH_O, LED_PORT_O}, 9'h000);
      for (int i = 0; i < 9; i++) lows[i] = 9'h000;
      repeat (240) begin
         @(posedge CLK);
         #1;
         for (int i = 0; i < 9; i++) begin
            if (oe_seen[i] === 1'b0) lows[i]++;
         end
      end
      for (int i = 0; i < 9; i++) begin
         c = (i < 8 && !GLOBAL_EN) ? PORT_LEVELS[4*i +: 4] : g;
         pb = (BLINK_EN && BLINK_PHASE) ? PHASE1_BITS[i] : PHASE0_BITS[i];
         check(lows[i], exp_low(m, c, pb));
         check(lows[i], exp_low(m, c, pb));
      end
   endtask : run_round

   // ------------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------------
   initial begin
      logic [31:0] r;
      repeat (5) @(posedge CLK);
      RST <= 1'b0;
      i_lipm_host.read_reg(8'h0E, rd_q);
      check({1'b0, rd_q}, 9'h000);
      i_lipm_host.write_reg(8'h3C, 8'h5A);
      i_lipm_host.read_reg(8'h0E, rd_q);
      check({1'b0, rd_q}, 9'h000);
      i_lipm_host.read_reg(8'h3C, rd_q);
      check({1'b0, rd_q}, 9'h000);
      drive(32'h7777_7777, 3'h3, 9'h0F0, 9'h1FF);
      run_round(4'hF, 4'h7);
      drive(32'hF0E0_F0E0, 3'h0, 9'h0A5, 9'h15A);
      run_round(4'h1, 4'hF);
      drive(32'h0123_4567, 3'h6, 9'h033, 9'h1CC);
      run_round(4'hE, 4'hE);
      drive(32'hFFFF_0000, 3'h4, 9'h00F, 9'h0F0);
      run_round(4'h0, 4'hF);
      repeat (20) begin
         r = $random(seed);
         drive($random(seed), r[2:0], r[11:3], r[20:12]);
         run_round(r[24:21], r[28:25]);
      end
      results();
   end

   initial begin
      #200000;
      err_count++;
      results();
   end

endmodule : tb_led_intensity_pwm_master_ninth_output
